// ==== rtl/tdp_defs.svh ====
`ifndef TDP_DEFS_SVH
`define TDP_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TDP_OFS_CTRL_ONE 8'h00
`define TDP_OFS_CTRL_TWO 8'h04
`define TDP_OFS_HIGH_BITS 8'h08
`define TDP_OFS_RELOAD_LOW 8'h0c
`define TDP_OFS_DUTY_LOW 8'h10
`define TDP_OFS_PRESC_CNT 8'h14
`define TDP_OFS_IRQ_TWO 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define TDP_C1_PWM_OE 7
`define TDP_C1_ACT_LOW 6
`define TDP_C1_HS_SRC 3
`define TDP_C1_ONE_SHOT 2
`define TDP_C1_RELOAD_SEL 1
`define TDP_C1_RUN 0
`define TDP_C2_CLK_SRC 5
`define TDP_C2_EDGE 4
`define TDP_C2_PRESC_EN_N 3
`define TDP_C2_RATIO_HI 2
`define TDP_HB_RELOAD_HI 7
`define TDP_HB_RELOAD_LO 6
`define TDP_HB_DUTY_HI 3
`define TDP_HB_DUTY_LO 2
`define TDP_IRQ_FLAG 6
`define TDP_IRQ_EN 2

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define TDP_CTRL_ONE_RST 8'h00
`define TDP_CTRL_TWO_RST 8'h08
`define TDP_COUNT_ALL_ONES 10'h3ff
`define TDP_COUNT_ZERO 10'h000
`define TDP_PRESC_ZERO 8'h00

`endif

// ==== rtl/tdp_pkg.sv ====
// ****************************************************************
// Shared types
// ****************************************************************
package tdp_pkg;
  typedef logic [7:0] tdp_addr_t;
  typedef logic [31:0] tdp_data_t;
  typedef logic [9:0] tdp_count_t;
  typedef logic [7:0] tdp_byte_t;
  // Timer input clock source
  typedef enum logic [1:0] {TDP_SRC_INSTR, TDP_SRC_EXT, TDP_SRC_FAST} tdp_src_e;
endpackage : tdp_pkg

// ==== rtl/tdp_timer_pwm.sv ====
`timescale 1ns/1ps
`include "tdp_defs.svh"
// Notes on behaviour
// - Ten-bit down counter fed by its own programmable prescaler.
// - High reload bits written first, low byte second; running load at underflow.
// - Writing low reload byte while stopped loads the counter at once.
// - Reading the timer location returns the live count.
// - Run bit starts counting when set, stops when cleared.
// - Fast source bit picks oscillator, else source bit picks pin or instruction.
// - Pin edge bit one counts falling edges, zero counts rising edges.
// - Prescaler active when enable_n is zero; ratio 1:2 to 1:256.
// - Prescaler internal count readable at a read-only location.
// - One-shot mode counts down once to zero, underflows, then stops.
// - Continuous mode restarts from reload value or all ones per select bit.
// - Underflow sets sticky flag; only a software zero write clears it.
// - Interrupt request when flag, timer enable and global enable all set.
// - PWM output enable drives the pin and forces output direction.
// - Polarity bit one means active low, zero means active high.
// - Duty is two upper bits plus low byte; zero never active.
// - Upper duty bits first, low byte second; active duty taken at underflow.
module tdp_timer_pwm
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire tdp_pkg::tdp_addr_t i_paddr,
  input wire tdp_pkg::tdp_data_t i_pwdata,
  output logic o_pready,
  output tdp_pkg::tdp_data_t o_prdata,
  output logic o_pslverr,
  // Timer clock sources
  input wire logic i_instr_tick,
  input wire logic i_external_clock_pin,
  input wire logic i_internal_fast_oscillator,
  // Interrupt
  input wire logic i_global_irq_enable,
  output logic o_irq_req,
  // PWM pin
  output logic o_pwm_out,
  output logic o_pwm_oe
);
  import tdp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [1:0] reload_hi_stage_reg;
  logic [1:0] duty_hi_stage_reg;
  tdp_count_t reload_buf_reg;
  tdp_count_t duty_buf_reg;
  tdp_count_t duty_active_reg;
  tdp_count_t count_reg;
  tdp_count_t count_next;
  tdp_byte_t presc_reg;
  logic underflow_flag_reg;
  logic irq_en_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic fast_meta_reg;
  logic fast_sync_reg;
  logic fast_prev_reg;
  logic pwm_out_reg;
  tdp_data_t prdata_reg;
  logic slverr_reg;
  tdp_src_e src_sel;
  logic src_tick;
  logic timer_tick;
  logic underflow;
  logic wr_access;
  logic rd_setup;
  logic wr_reload_low;
  logic wr_duty_low;
  logic wr_ctrl_one;
  logic pwm_active;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Terminal prescaler count for a ratio code: 1:2 ends at 1, 1:256 at 255
  function automatic tdp_byte_t presc_last(input logic [2:0] ratio);
    tdp_byte_t full;
    full = 8'hff;
    presc_last = full >> (3'h7 - ratio);
  endfunction : presc_last

  // Address match
  function automatic logic addr_is(input tdp_addr_t addr, input tdp_addr_t ofs);
    addr_is = (addr == ofs);
  endfunction : addr_is

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Zero wait states: every access completes in its first access cycle
  assign o_pready = 1'b1;
  assign wr_access = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable;
  assign wr_ctrl_one = wr_access & addr_is(i_paddr, `TDP_OFS_CTRL_ONE);
  assign wr_reload_low = wr_access & addr_is(i_paddr, `TDP_OFS_RELOAD_LOW);
  assign wr_duty_low = wr_access & addr_is(i_paddr, `TDP_OFS_DUTY_LOW);
  assign o_prdata = prdata_reg;
  assign o_pslverr = slverr_reg & i_psel & i_penable;

  // Read data and error captured in setup, stable through the access phase
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end
    else if (rd_setup)
    begin
      slverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      case (i_paddr)
        `TDP_OFS_CTRL_ONE: prdata_reg <= {24'h00_0000, ctrl_one_reg};
        `TDP_OFS_CTRL_TWO: prdata_reg <= {24'h00_0000, ctrl_two_reg};
        `TDP_OFS_HIGH_BITS: prdata_reg <= {24'h00_0000, reload_hi_stage_reg, 2'h0,
                                           duty_hi_stage_reg, 2'h0};
        `TDP_OFS_RELOAD_LOW: prdata_reg <= {22'h0, count_reg};
        `TDP_OFS_DUTY_LOW: prdata_reg <= {22'h0, duty_buf_reg};
        `TDP_OFS_PRESC_CNT: prdata_reg <= {24'h00_0000, presc_reg};
        `TDP_OFS_IRQ_TWO: prdata_reg <= {25'h0, underflow_flag_reg, 3'h0,
                                         irq_en_reg, 2'h0};
        default: slverr_reg <= 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Run bit is dropped by hardware after a one-shot underflow
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ctrl_one_reg <= `TDP_CTRL_ONE_RST;
    else if (wr_ctrl_one)
      ctrl_one_reg <= i_pwdata[7:0];
    else if (underflow && ctrl_one_reg[`TDP_C1_ONE_SHOT])
      ctrl_one_reg[`TDP_C1_RUN] <= 1'b0;
  end

  // Clock source and prescaler settings
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ctrl_two_reg <= `TDP_CTRL_TWO_RST;
    else if (wr_access && addr_is(i_paddr, `TDP_OFS_CTRL_TWO))
      ctrl_two_reg <= {2'h0, i_pwdata[5:0]};
  end

  // Staged upper bits, only meaningful once the low byte follows
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      reload_hi_stage_reg <= 2'h0;
      duty_hi_stage_reg <= 2'h0;
    end
    else if (wr_access && addr_is(i_paddr, `TDP_OFS_HIGH_BITS))
    begin
      reload_hi_stage_reg <= i_pwdata[`TDP_HB_RELOAD_HI:`TDP_HB_RELOAD_LO];
      duty_hi_stage_reg <= i_pwdata[`TDP_HB_DUTY_HI:`TDP_HB_DUTY_LO];
    end
  end

  // Low byte write commits the buffered ten-bit values
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      reload_buf_reg <= `TDP_COUNT_ZERO;
      duty_buf_reg <= `TDP_COUNT_ZERO;
    end
    else
    begin
      if (wr_reload_low)
        reload_buf_reg <= {reload_hi_stage_reg, i_pwdata[7:0]};
      if (wr_duty_low)
        duty_buf_reg <= {duty_hi_stage_reg, i_pwdata[7:0]};
    end
  end

  // ****************************************************************
  // Clock source selection
  // ****************************************************************
  // Two-stage synchronisers plus a delay flop; edges compare the second stage with the delay flop
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      fast_meta_reg <= 1'b0;
      fast_sync_reg <= 1'b0;
      fast_prev_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= i_external_clock_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      fast_meta_reg <= i_internal_fast_oscillator;
      fast_sync_reg <= fast_meta_reg;
      fast_prev_reg <= fast_sync_reg;
    end
  end

  // Fast oscillator must run below half of i_clk or edges are lost
  always_comb
  begin
    if (ctrl_one_reg[`TDP_C1_HS_SRC])
      src_sel = TDP_SRC_FAST;
    else if (ctrl_two_reg[`TDP_C2_CLK_SRC])
      src_sel = TDP_SRC_EXT;
    else
      src_sel = TDP_SRC_INSTR;
    case (src_sel)
      TDP_SRC_FAST: src_tick = fast_sync_reg & ~fast_prev_reg;
      TDP_SRC_EXT: src_tick = ctrl_two_reg[`TDP_C2_EDGE] ?
                              (~ext_sync_reg & ext_prev_reg) :
                              (ext_sync_reg & ~ext_prev_reg);
      default: src_tick = i_instr_tick;
    endcase
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  // Bypassed prescaler passes every source tick straight through
  assign timer_tick = ctrl_one_reg[`TDP_C1_RUN] & src_tick &
                      (ctrl_two_reg[`TDP_C2_PRESC_EN_N] |
                       (presc_reg == presc_last(ctrl_two_reg[`TDP_C2_RATIO_HI:0])));

  // Held at zero while stopped or bypassed so the next start is clean
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      presc_reg <= `TDP_PRESC_ZERO;
    else if (!ctrl_one_reg[`TDP_C1_RUN] || ctrl_two_reg[`TDP_C2_PRESC_EN_N])
      presc_reg <= `TDP_PRESC_ZERO;
    else if (src_tick)
      presc_reg <= timer_tick ? `TDP_PRESC_ZERO : presc_reg + 8'h01;
  end

  // ****************************************************************
  // Down counter
  // ****************************************************************
  assign underflow = timer_tick & (count_reg == `TDP_COUNT_ZERO);

  // Next count: immediate load when stopped, reload on underflow, else decrement
  always_comb
  begin
    count_next = count_reg;
    if (wr_reload_low && !ctrl_one_reg[`TDP_C1_RUN])
      count_next = {reload_hi_stage_reg, i_pwdata[7:0]};
    else if (underflow)
    begin
      if (ctrl_one_reg[`TDP_C1_ONE_SHOT] || ctrl_one_reg[`TDP_C1_RELOAD_SEL])
        count_next = reload_buf_reg;
      else
        count_next = `TDP_COUNT_ALL_ONES;
    end
    else if (timer_tick)
      count_next = count_reg - 10'h001;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      count_reg <= `TDP_COUNT_ZERO;
    else
      count_reg <= count_next;
  end

  // ****************************************************************
  // Underflow flag and interrupt
  // ****************************************************************
  // Set beats a simultaneous software clear so no underflow is lost
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      underflow_flag_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end
    else
    begin
      if (underflow)
        underflow_flag_reg <= 1'b1;
      else if (wr_access && addr_is(i_paddr, `TDP_OFS_IRQ_TWO) &&
               !i_pwdata[`TDP_IRQ_FLAG])
        underflow_flag_reg <= 1'b0;
      if (wr_access && addr_is(i_paddr, `TDP_OFS_IRQ_TWO))
        irq_en_reg <= i_pwdata[`TDP_IRQ_EN];
    end
  end

  assign o_irq_req = underflow_flag_reg & irq_en_reg & i_global_irq_enable;

  // ****************************************************************
  // PWM
  // ****************************************************************
  // New duty only at frame boundary, so a frame never sees a torn value
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      duty_active_reg <= `TDP_COUNT_ZERO;
    else if (underflow)
      duty_active_reg <= duty_buf_reg;
  end

  // Zero duty never active; otherwise active at or below the duty value
  assign pwm_active = (duty_active_reg != `TDP_COUNT_ZERO) &&
                      (count_reg <= duty_active_reg);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pwm_out_reg <= 1'b0;
    else
      pwm_out_reg <= pwm_active ^ ctrl_one_reg[`TDP_C1_ACT_LOW];
  end

  // Pin is driven only while enabled; enable also forces output direction
  assign o_pwm_out = pwm_out_reg & ctrl_one_reg[`TDP_C1_PWM_OE];
  assign o_pwm_oe = ctrl_one_reg[`TDP_C1_PWM_OE];

endmodule : tdp_timer_pwm

// ==== test/tdp_timer_pwm_chk.sv ====
`timescale 1ns/1ps
`include "tdp_defs.svh"
// ****
// Port checker
// ****
module tdp_timer_pwm_chk
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire tdp_pkg::tdp_addr_t i_paddr,
  input wire tdp_pkg::tdp_data_t i_pwdata,
  input wire logic o_pready,
  input wire tdp_pkg::tdp_data_t o_prdata,
  input wire logic o_pslverr,
  // Sources and pins
  input wire logic i_instr_tick,
  input wire logic i_external_clock_pin,
  input wire logic i_internal_fast_oscillator,
  input wire logic i_global_irq_enable,
  input wire logic o_irq_req,
  input wire logic o_pwm_out,
  input wire logic o_pwm_oe
);
  import tdp_pkg::*;
  logic acc;
  logic [2:0] quiet_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  assign acc = i_psel && i_penable && o_pready;
  // Quiet time must outlast the sync stages, else a late edge slips past
  // Synchronous clear leaves one clock for the sampled-value calls below
  always_ff @(posedge i_clk)
    if (!i_rstn)
      quiet_reg <= 3'h0;
    else if (i_instr_tick || i_psel || !$stable(i_external_clock_pin) ||
             !$stable(i_internal_fast_oscillator) || !$stable(i_global_irq_enable))
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  // ****
  // Properties
  // ****
  property p_irq_gate; o_irq_req |-> i_global_irq_enable; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
  property p_oe_set; acc && i_pwrite && i_paddr == `TDP_OFS_CTRL_ONE |=>
    o_pwm_oe == $past(i_pwdata[7]); endproperty
  a_oe_set: assert property (p_oe_set) else $error("output enable not written");
  property p_oe_hold; $changed(o_pwm_oe) |->
    $past(acc && i_pwrite && i_paddr == `TDP_OFS_CTRL_ONE); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("output enable moved alone");
  property p_pin_off; !o_pwm_oe [*2] |-> !o_pwm_out; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");
  property p_sticky; $fell(o_irq_req) |-> !i_global_irq_enable ||
    $past(acc && i_pwrite && i_paddr == `TDP_OFS_IRQ_TWO); endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped by itself");
  property p_cnt_rd; acc && !i_pwrite && i_paddr == `TDP_OFS_RELOAD_LOW |->
    o_prdata[31:10] == 22'h0; endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count read too wide");
  property p_ps_rd; acc && !i_pwrite && i_paddr == `TDP_OFS_PRESC_CNT |->
    o_prdata[31:8] == 24'h0; endproperty
  a_ps_rd: assert property (p_ps_rd) else $error("prescaler read too wide");
  property p_quiet; quiet_reg == 3'h7 |-> $stable(o_pwm_out) && $stable(o_irq_req); endproperty
  a_quiet: assert property (p_quiet) else $error("outputs moved without cause");
  c_irq: cover property ($rose(o_irq_req));
  c_pwm: cover property (o_pwm_oe && o_pwm_out);
  c_err: cover property (acc && o_pslverr);
endmodule : tdp_timer_pwm_chk

bind tdp_timer_pwm tdp_timer_pwm_chk u_chk
(
  .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_instr_tick(i_instr_tick),
  .i_external_clock_pin(i_external_clock_pin), .o_irq_req(o_irq_req),
  .i_internal_fast_oscillator(i_internal_fast_oscillator),
  .i_global_irq_enable(i_global_irq_enable), .o_pwm_out(o_pwm_out), .o_pwm_oe(o_pwm_oe)
);

// ==== test/tdp_pin_partner.sv ====
`timescale 1ns/1ps
// ****
// External clock pin source
// ****
module tdp_pin_partner
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Burst request
  input wire logic i_go,
  input wire logic [3:0] i_pulses,
  input wire logic i_slow,
  output logic o_busy,
  // Clock pin
  output logic o_pin
);
  logic [4:0] left_reg;
  logic [2:0] gap_reg;
  // Pin stands still between bursts; slow bursts stretch each level
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      left_reg <= 5'h0;
      gap_reg <= 3'h0;
      o_pin <= 1'b0;
    end
    else if (i_go)
      left_reg <= {i_pulses, 1'b0};
    else if (left_reg != 5'h0)
    begin
      gap_reg <= gap_reg + 3'h1;
      if (gap_reg == (i_slow ? 3'h7 : 3'h3))
      begin
        gap_reg <= 3'h0;
        o_pin <= ~o_pin;
        left_reg <= left_reg - 5'h1;
      end
    end
  end
  assign o_busy = (left_reg != 5'h0);
endmodule : tdp_pin_partner

// ==== test/test_timer_down10_pwm_unit.sv ====
`timescale 1ns/1ps
`include "tdp_defs.svh"
module test_timer_down10_pwm_unit;
  import tdp_pkg::*;
  typedef struct {tdp_addr_t a; tdp_data_t e;} tdp_note_s;
  localparam tdp_addr_t c1 = `TDP_OFS_CTRL_ONE;
  localparam tdp_addr_t rl = `TDP_OFS_RELOAD_LOW;
  localparam tdp_addr_t iq = `TDP_OFS_IRQ_TWO;
  logic clk, rstn, psel, pen, pwr, tick, fosc, global_irq_enable, go, slow, obs_req;
  logic pready, perr, irq, pwm, oe, pin, busy;
  logic [3:0] npul;
  tdp_addr_t paddr;
  tdp_data_t pwdata, prdata;
  int miscompares, n_compared, k, m;
  tdp_note_s notes[$];
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  tdp_timer_pwm dut
  (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(perr), .i_instr_tick(tick), .i_external_clock_pin(pin),
    .i_internal_fast_oscillator(fosc), .i_global_irq_enable(global_irq_enable), .o_irq_req(irq),
    .o_pwm_out(pwm), .o_pwm_oe(oe)
  );
  tdp_pin_partner u_pin
  (
    .i_clk(clk), .i_rstn(rstn), .i_go(go), .i_pulses(npul), .i_slow(slow),
    .o_busy(busy), .o_pin(pin)
  );
  // ****
  // Result watcher
  // ****
  always @(posedge clk)
    if (obs_req || (psel && pen && !pwr && pready === 1'b1))
    begin
      chk(notes[0].a, notes[0].e, obs_req ? {29'h0, irq, oe, pwm} : prdata);
      if (!obs_req)
        chk(8'hfe, {31'h0, notes[0].a > iq}, {31'h0, perr});
      void'(notes.pop_front());
    end
  // ****
  // Tasks
  // ****
  task automatic chk(input tdp_addr_t a, input tdp_data_t e, input tdp_data_t g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] item %h expected %h seen %h", a, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic hold(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v)
    begin
      n++;
      if (n > 400)
      begin
        $display("[FAIL] wait expected %b seen %b", v, s);
        miscompares++;
        finish_test();
      end
      @(posedge clk);
    end
  endtask : hold
  task automatic wr(input tdp_addr_t a, input tdp_data_t d, input logic w = 1'b1);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    hold(pready, 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input tdp_addr_t a, input tdp_data_t e);
    notes.push_back('{a, e});
    wr(a, 32'h0, 1'b0);
  endtask : rd
  task automatic obs(input logic [2:0] e);
    notes.push_back('{8'hff, {29'h0, e}});
    obs_req <= 1'b1;
    @(posedge clk);
    obs_req <= 1'b0;
  endtask : obs
  // Two cycles per tick, one high and one low, then room for the output flop
  task automatic ticks(input int n);
    repeat (n)
    begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
  endtask : ticks
  task automatic pulses(input logic [3:0] n);
    npul <= n;
    slow <= 1'($urandom_range(0, 1));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    hold(busy, 1'b0);
    repeat (8) @(posedge clk);
  endtask : pulses
  task automatic load(input tdp_count_t v);
    wr(`TDP_OFS_HIGH_BITS, {24'h0, v[9:8], 6'h0});
    wr(rl, {24'h0, v[7:0]});
  endtask : load
  task automatic frame(input logic pol, input int duty);
    for (int c = 4; c >= 0; c--)
    begin
      obs({2'b01, pol ^ (duty != 0 && c <= duty)});
      ticks(1);
    end
  endtask : frame
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    $display("[FAIL] run expected end seen timeout");
    miscompares++;
    finish_test();
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    {rstn, psel, pen, pwr, tick, fosc, global_irq_enable, go, slow, obs_req} = '0;
    paddr = '0;
    pwdata = '0;
    npul = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h973c));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(c1, 32'h0);
    rd(`TDP_OFS_CTRL_TWO, 32'h08);
    wr(8'h1c, 32'hff);
    rd(8'h1c, 32'h0);
    wr(`TDP_OFS_HIGH_BITS, 32'h8c);
    rd(`TDP_OFS_HIGH_BITS, 32'h8c);
    wr(`TDP_OFS_DUTY_LOW, 32'h5a);
    rd(`TDP_OFS_DUTY_LOW, 32'h35a);
    load(10'h2c5);
    rd(rl, 32'h2c5);
    wr(`TDP_OFS_DUTY_LOW, 32'h0);
    load(10'h003);
    rd(rl, 32'h003);
    wr(c1, 32'h03);
    ticks(2);
    load(10'h005);
    rd(rl, 32'h001);
    ticks(2);
    rd(rl, 32'h005);
    rd(iq, 32'h40);
    global_irq_enable <= 1'b1;
    wr(iq, 32'h44);
    obs(3'b100);
    global_irq_enable <= 1'b0;
    @(posedge clk);
    obs(3'b000);
    global_irq_enable <= 1'b1;
    ticks(1);
    obs(3'b100);
    wr(iq, 32'h04);
    rd(iq, 32'h04);
    wr(c1, 32'h02);
    ticks(3);
    rd(rl, 32'h004);
    load(10'h005);
    wr(c1, 32'h01);
    ticks(6);
    rd(rl, 32'h3ff);
    wr(c1, 32'h0);
    load(10'h002);
    wr(c1, 32'h05);
    ticks(3);
    rd(c1, 32'h04);
    ticks(2);
    rd(rl, 32'h002);
    wr(iq, 32'h0);
    $display("count tests done");
    for (int r = 0; r < 8; r++)
    begin
      k = $urandom_range(1, 3);
      m = $urandom_range(0, (2 << r) - 1);
      wr(c1, 32'h0);
      wr(`TDP_OFS_CTRL_TWO, 32'(r));
      load(10'h010);
      wr(c1, 32'h03);
      ticks((2 << r) * k + m);
      rd(`TDP_OFS_PRESC_CNT, 32'(m));
      rd(rl, 32'(16 - k));
    end
    $display("prescaler tests done");
    wr(c1, 32'h0);
    wr(`TDP_OFS_CTRL_TWO, 32'h28);
    load(10'h010);
    wr(c1, 32'h03);
    ticks(2);
    rd(rl, 32'h010);
    pulses(4'h3);
    rd(rl, 32'h00d);
    wr(`TDP_OFS_CTRL_TWO, 32'h38);
    pulses(4'h3);
    rd(rl, 32'h00a);
    wr(c1, 32'h0b);
    repeat (4)
    begin
      fosc <= 1'b1;
      repeat (3) @(posedge clk);
      fosc <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    rd(rl, 32'h006);
    pulses(4'h2);
    rd(rl, 32'h006);
    $display("source tests done");
    wr(c1, 32'h0);
    wr(`TDP_OFS_CTRL_TWO, 32'h08);
    load(10'h004);
    wr(`TDP_OFS_DUTY_LOW, 32'h02);
    rd(`TDP_OFS_DUTY_LOW, 32'h002);
    wr(c1, 32'h83);
    frame(1'b0, 0);
    frame(1'b0, 2);
    wr(c1, 32'h03);
    ticks(3);
    obs(3'b000);
    ticks(2);
    wr(c1, 32'hc3);
    frame(1'b1, 2);
    wr(`TDP_OFS_DUTY_LOW, 32'h0);
    frame(1'b1, 2);
    frame(1'b1, 0);
    $display("pwm tests done");
    finish_test();
  end
endmodule : test_timer_down10_pwm_unit
